// File: src/stf_framer.sv
// Notes on behaviour
// - Telegram opens with start byte 0x02
// - Length byte counts bytes after itself
// - Ordinary telegram acts only on node match
// - Broadcast bit: all slaves act, no address
// - Mirror bit: matching slave echoes telegram unchanged
// - Check byte is XOR of preceding bytes
// - Idle of two characters precedes each telegram
// - One character spans eleven bit periods
// - Inter-character gap shorter than start delay
// - Device is slave only, answers master
// - Point-to-point port uses same protocol
// - Fixed and variable telegram lengths supported
// - Common fixed telegram is 16 bytes
// - Node address configurable from 0 to 30
// - Supervision timeout 0..65535 ms, zero disables
// - Process words 0..8, channel 0/3/4/variable
`timescale 1ns/1ps
`default_nettype none
module stf_framer
  import stf_pkg::*;
#(
  parameter int BIT_CYCLES = 2170,
  parameter int MS_CYCLES = STF_CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic port_select,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_line_idle,
  input wire logic [4:0] node_address_setting,
  input wire logic [3:0] process_word_count_setting,
  input wire logic [6:0] parameter_channel_length_setting,
  input wire logic [15:0] telegram_timeout_setting,
  output logic frame_byte_valid,
  output stf_byte_t frame_byte,
  output logic frame_done,
  output stf_verdict_t frame_verdict,
  output logic reply_enable,
  output logic mirror_request,
  output logic frame_error,
  output logic config_error,
  output logic telegram_timeout,
  output logic [7:0] active_port
);
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CHAR_CYCLES = BIT_CYCLES * STF_BITS_PER_CHAR;
  localparam int DELAY_CYCLES = CHAR_CYCLES * STF_START_DELAY_CHARS;

  function automatic logic addr_ok(input logic [7:0] a, input logic [4:0] me);
    addr_ok = (a[4:0] == me);
  endfunction

  // ---------------------------------------------------------------
  // Frame state
  // ---------------------------------------------------------------
  stf_state_t state_reg, state_next;
  logic [7:0] remain_reg, remain_next;
  logic [7:0] xor_reg, xor_next;
  logic [7:0] addr_reg, addr_next;
  logic addr_seen_reg, addr_seen_next;
  logic [31:0] idle_reg, idle_next;
  logic [31:0] ms_reg, ms_next;
  logic [15:0] tmo_reg, tmo_next;
  logic fbv_next, done_next, err_next, tout_next;
  stf_byte_t fb_next;
  stf_verdict_t verd_next;
  logic rep_next, mir_next;
  logic gap_ok;
  logic me_hit;
  logic [7:0] port_next;

  assign gap_ok = (idle_reg >= 32'(DELAY_CYCLES));
  assign me_hit = addr_ok(addr_reg, node_address_setting);

  always_comb begin
    state_next = state_reg;
    remain_next = remain_reg;
    xor_next = xor_reg;
    addr_next = addr_reg;
    addr_seen_next = addr_seen_reg;
    idle_next = rx_line_idle ? ((idle_reg == 32'hffff_ffff) ? idle_reg : idle_reg + 32'd1)
                             : 32'd0;
    ms_next = ms_reg;
    tmo_next = tmo_reg;
    fbv_next = 1'b0;
    fb_next = '0;
    done_next = 1'b0;
    err_next = 1'b0;
    tout_next = telegram_timeout;
    verd_next = frame_verdict;
    rep_next = 1'b0;
    mir_next = 1'b0;
    port_next = {7'd0, port_select};
    // Supervision timer restarts on each good broadcast telegram, or good telegram for this node while config_error is low
    if (telegram_timeout_setting == 16'd0) begin
      tout_next = 1'b0;
      tmo_next = 16'd0;
      ms_next = 32'd0;
    end else if (!telegram_timeout) begin
      if (ms_reg + 32'd1 >= 32'(MS_CYCLES)) begin
        ms_next = 32'd0;
        tmo_next = tmo_reg + 16'd1;
        if (tmo_reg + 16'd1 >= telegram_timeout_setting) begin
          tout_next = 1'b1;
        end
      end else begin
        ms_next = ms_reg + 32'd1;
      end
    end
    unique case (state_reg)
      STF_IDLE: begin
        if (rx_valid && rx_byte == STF_START_BYTE && gap_ok) begin
          state_next = STF_LEN;
          xor_next = rx_byte;
          addr_seen_next = 1'b0;
          fbv_next = 1'b1;
          fb_next = '{data: rx_byte, last: 1'b0};
        end
      end
      STF_LEN: begin
        if (rx_valid) begin
          if (rx_byte < 8'd2) begin
            state_next = STF_DROP;
            err_next = 1'b1;
          end else begin
            remain_next = rx_byte;
            xor_next = xor_reg ^ rx_byte;
            state_next = STF_BODY;
            fbv_next = 1'b1;
            fb_next = '{data: rx_byte, last: 1'b0};
          end
        end else if (gap_ok) begin
          state_next = STF_IDLE;
          err_next = 1'b1;
        end
      end
      STF_BODY: begin
        if (rx_valid) begin
          remain_next = remain_reg - 8'd1;
          fbv_next = 1'b1;
          fb_next = '{data: rx_byte, last: remain_reg == 8'd1};
          if (!addr_seen_reg) begin
            addr_next = rx_byte;
            addr_seen_next = 1'b1;
          end
          if (remain_reg == 8'd1) begin
            state_next = STF_IDLE;
            done_next = 1'b1;
            verd_next.good = (xor_reg == rx_byte);
            verd_next.bcast = addr_reg[STF_ADDR_BCAST_BIT];
            verd_next.mirror = addr_reg[STF_ADDR_MIRROR_BIT];
            verd_next.special = addr_reg[STF_ADDR_SPECIAL_BIT];
            err_next = (xor_reg != rx_byte);
            if (xor_reg == rx_byte) begin
              if (addr_reg[STF_ADDR_BCAST_BIT]) begin
                rep_next = 1'b0;
                tmo_next = 16'h0000;
                ms_next = 32'h0000_0000;
                tout_next = 1'b0;
              end else if (me_hit && !config_error) begin
                rep_next = 1'b1;
                mir_next = addr_reg[STF_ADDR_MIRROR_BIT];
                tmo_next = 16'd0;
                ms_next = 32'd0;
                tout_next = 1'b0;
              end
            end
          end else begin
            xor_next = xor_reg ^ rx_byte;
          end
        end else if (gap_ok) begin
          state_next = STF_IDLE;
          err_next = 1'b1;
        end
      end
      STF_DROP: begin
        if (gap_ok) begin
          state_next = STF_IDLE;
        end
      end
      default: state_next = STF_IDLE;
    endcase
  end

  assign config_error = (node_address_setting > STF_MAX_NODE)
    || (process_word_count_setting > STF_MAX_PD_WORDS)
    || !(parameter_channel_length_setting == STF_PC_LEN_NONE
      || parameter_channel_length_setting == STF_PC_LEN_THREE
      || parameter_channel_length_setting == STF_PC_LEN_FOUR
      || parameter_channel_length_setting == STF_PC_LEN_VARIABLE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= STF_IDLE;
      remain_reg <= STF_RESET_BYTE;
      xor_reg <= STF_RESET_BYTE;
      addr_reg <= STF_RESET_BYTE;
      addr_seen_reg <= 1'b0;
      idle_reg <= '0;
      ms_reg <= '0;
      tmo_reg <= '0;
      frame_byte_valid <= 1'b0;
      frame_byte <= '0;
      frame_done <= 1'b0;
      frame_verdict <= '0;
      reply_enable <= 1'b0;
      mirror_request <= 1'b0;
      frame_error <= 1'b0;
      telegram_timeout <= 1'b0;
      active_port <= STF_RESET_BYTE;
    end else begin
      state_reg <= state_next;
      remain_reg <= remain_next;
      xor_reg <= xor_next;
      addr_reg <= addr_next;
      addr_seen_reg <= addr_seen_next;
      idle_reg <= idle_next;
      ms_reg <= ms_next;
      tmo_reg <= tmo_next;
      frame_byte_valid <= fbv_next;
      frame_byte <= fb_next;
      frame_done <= done_next;
      frame_verdict <= verd_next;
      reply_enable <= rep_next;
      mirror_request <= mir_next;
      frame_error <= err_next;
      telegram_timeout <= tout_next;
      active_port <= port_next;
    end
  end
endmodule
`default_nettype wire

// File: src/stf_pkg.sv
package stf_pkg;
  // ---------------------------------------------------------------
  // Protocol constants
  // ---------------------------------------------------------------
  localparam logic [7:0] STF_START_BYTE = 8'h02;
  localparam int STF_FRAME_OVERHEAD = 2;
  localparam int STF_BITS_PER_CHAR = 11;
  localparam int STF_START_DELAY_CHARS = 2;
  localparam int STF_ADDR_BCAST_BIT = 5;
  localparam int STF_ADDR_MIRROR_BIT = 6;
  localparam int STF_ADDR_SPECIAL_BIT = 7;
  localparam logic [4:0] STF_MAX_NODE = 5'h1e;
  localparam logic [3:0] STF_MAX_PD_WORDS = 4'h8;
  localparam logic [6:0] STF_PC_LEN_NONE = 7'h00;
  localparam logic [6:0] STF_PC_LEN_THREE = 7'h03;
  localparam logic [6:0] STF_PC_LEN_FOUR = 7'h04;
  localparam logic [6:0] STF_PC_LEN_VARIABLE = 7'h7f;
  localparam int STF_CLK_HZ = 250_000_000;
  localparam int STF_CYCLES_PER_MS = STF_CLK_HZ / 1000;
  localparam logic [7:0] STF_RESET_BYTE = 8'h00;

  typedef enum logic [2:0] {
    STF_IDLE, STF_LEN, STF_BODY, STF_DROP
  } stf_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } stf_byte_t;

  typedef struct packed {
    logic good;
    logic bcast;
    logic mirror;
    logic special;
  } stf_verdict_t;
endpackage

// File: tb/stf_chk.sv
`timescale 1ns/1ps
`default_nettype none
module stf_chk
  import stf_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic [4:0] node_address_setting,
  input wire logic [15:0] telegram_timeout_setting,
  input wire logic frame_byte_valid,
  input wire stf_byte_t frame_byte,
  input wire logic frame_done,
  input wire stf_verdict_t frame_verdict,
  input wire logic reply_enable,
  input wire logic mirror_request,
  input wire logic frame_error,
  input wire logic config_error,
  input wire logic telegram_timeout
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_BYTE_ECHO: assert property (
    frame_byte_valid |-> $past(rx_valid) && frame_byte.data == $past(rx_byte))
    else $error("frame byte not taken from input");
  AST_DONE_ON_LAST: assert property (frame_done |-> frame_byte_valid && frame_byte.last)
    else $error("frame done without check byte");
  AST_REPLY_CAUSE: assert property (
    reply_enable |-> frame_done && frame_verdict.good && !frame_verdict.bcast
      && !$past(config_error))
    else $error("reply without good addressed frame");
  AST_BCAST_CLEARS: assert property (
    frame_done && frame_verdict.good && frame_verdict.bcast |-> ##[0:1] !telegram_timeout)
    else $error("broadcast did not clear timeout");
  AST_MIRROR: assert property (mirror_request |-> reply_enable && frame_verdict.mirror)
    else $error("mirror request without mirror reply");
  AST_ERR_SILENT: assert property (frame_error |-> !reply_enable && !mirror_request)
    else $error("reply on bad frame");
  AST_NODE_RANGE: assert property (node_address_setting > STF_MAX_NODE |-> config_error)
    else $error("node out of range not flagged");
  AST_TIMEOUT_OFF: assert property (
    (telegram_timeout_setting == 16'h0000) [*2] |-> !telegram_timeout)
    else $error("timeout while disabled");
  AST_VERDICT_HOLD: assert property ($changed(frame_verdict) |-> frame_done || frame_error)
    else $error("verdict changed between frames");
endmodule
bind stf_framer stf_chk chk_u (
  .clk(clk), .rstn(rstn), .rx_valid(rx_valid), .rx_byte(rx_byte),
  .node_address_setting(node_address_setting),
  .telegram_timeout_setting(telegram_timeout_setting),
  .frame_byte_valid(frame_byte_valid), .frame_byte(frame_byte), .frame_done(frame_done),
  .frame_verdict(frame_verdict), .reply_enable(reply_enable),
  .mirror_request(mirror_request), .frame_error(frame_error),
  .config_error(config_error), .telegram_timeout(telegram_timeout));
`default_nettype wire

// File: tb/stf_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module stf_master_model (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_line_idle
);
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_line_idle = 1'b1;
  end
  task automatic send(input logic [7:0] q[$], input int idl);
    rx_line_idle <= 1'b0;
    @(posedge clk);
    rx_line_idle <= 1'b1;
    repeat (idl) @(posedge clk);
    foreach (q[i]) begin
      rx_line_idle <= 1'b0;
      rx_valid <= 1'b1;
      rx_byte <= q[i];
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_byte <= ~q[i];
      @(posedge clk);
    end
    rx_line_idle <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_stf_framer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_stf_framer;
  import stf_pkg::*;
  logic clk, rstn, port_sel, rx_valid, rx_line_idle, fbv, done, rep, mir, ferr, cerr, tout;
  logic [7:0] rx_byte;
  logic [4:0] node;
  logic [6:0] pc_len;
  logic [15:0] tmo;
  logic [2:0] got;
  logic [7:0] aport;
  logic [3:0] pd_words;
  int nbytes = 0;
  int ndone = 0;
  localparam int BIT_CYC = 1;
  localparam int GAP = STF_BITS_PER_CHAR * STF_START_DELAY_CHARS * BIT_CYC;
  stf_byte_t fb;
  stf_verdict_t verd;
  logic [7:0] addr_tab[4] = '{8'h05, 8'h06, 8'h29, 8'h45};
  int failures = 0;
  int compares = 0;
  stf_framer #(.BIT_CYCLES(BIT_CYC), .MS_CYCLES(10)) dut_u (
    .clk(clk), .rstn(rstn), .port_select(port_sel), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_line_idle(rx_line_idle), .node_address_setting(node),
    .process_word_count_setting(pd_words), .parameter_channel_length_setting(pc_len),
    .telegram_timeout_setting(tmo), .frame_byte_valid(fbv), .frame_byte(fb),
    .frame_done(done), .frame_verdict(verd), .reply_enable(rep), .mirror_request(mir),
    .frame_error(ferr), .config_error(cerr), .telegram_timeout(tout), .active_port(aport));
  stf_master_model pm_u (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_line_idle(rx_line_idle));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rep) got[0] <= 1'b1;
    if (mir) got[1] <= 1'b1;
    if (ferr) got[2] <= 1'b1;
    if (fbv) nbytes <= nbytes + 1;
    if (done) ndone <= ndone + 1;
  end
  function automatic logic cfg_ok();
    return node <= STF_MAX_NODE && pd_words <= STF_MAX_PD_WORDS &&
      pc_len inside {STF_PC_LEN_NONE, STF_PC_LEN_THREE, STF_PC_LEN_FOUR, STF_PC_LEN_VARIABLE};
  endfunction
  function automatic logic [7:0] expect_of(logic [7:0] adr, int mode, int idl);
    logic ok;
    ok = idl >= GAP && mode == 0 && cfg_ok() && adr[4:0] == node;
    return {5'h00, idl >= GAP && mode != 0, ok && !adr[5] && adr[6], ok && !adr[5]};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize;
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic run(input logic [7:0] adr, input int n, input int mode, input int idl);
    logic [7:0] q[$];
    logic [7:0] x;
    stf_verdict_t vexp;
    int nexp;
    q = {STF_START_BYTE, 8'(n + 2), adr};
    repeat (n) q.push_back(8'($urandom));
    x = 8'h00;
    foreach (q[i]) x ^= q[i];
    q.push_back(x ^ {7'h00, mode == 1});
    if (mode == 2) q = q[0:$-2];
    if (mode == 3) q[1] = 8'h01;
    vexp = (idl >= GAP && mode < 2) ? {mode == 0, adr[5], adr[6], adr[7]} : verd;
    nexp = (idl < GAP) ? 0 : ((mode == 3) ? 1 : q.size());
    port_sel <= 1'($urandom);
    got = 3'h0;
    nbytes = 0;
    ndone = 0;
    pm_u.send(q, idl);
    repeat (30) @(posedge clk);
    chk({5'h00, got}, expect_of(adr, mode, idl));
    chk({4'h0, verd}, {4'h0, vexp});
    chk(8'(nbytes), 8'(nexp));
    chk(8'(ndone), 8'(idl >= GAP && mode < 2));
    chk(aport, {7'h00, port_sel});
    chk({7'h00, cerr}, {7'h00, !cfg_ok()});
  endtask
  initial begin
    rstn = 1'b0;
    port_sel = 1'b0;
    node = 5'h05;
    pc_len = STF_PC_LEN_FOUR;
    pd_words = 4'h2;
    tmo = 16'h0004;
    got = 3'h0;
    void'($urandom(32'h7439));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (50) @(posedge clk);
    chk({7'h00, tout}, 8'h01);
    run(8'h05, 12, 0, 24);
    chk({7'h00, tout}, 8'h00);
    repeat (50) @(posedge clk);
    chk({7'h00, tout}, 8'h01);
    run(8'h29, 5, 0, 24);
    chk({7'h00, tout}, 8'h00);
    tmo <= 16'h0000;
    run(8'h06, 3, 0, 24);
    run(8'h29, 5, 0, 24);
    run(8'h45, 2, 0, 24);
    run(8'h05, 4, 1, 24);
    run(8'h05, 6, 2, 24);
    run(8'h05, 3, 0, 5);
    run(8'h05, 3, 0, 22);
    run(8'h05, 3, 0, 21);
    run(8'h05, 4, 3, 24);
    repeat (8) run(addr_tab[$urandom % 4], 1 + $urandom % 20, 0, 24);
    node <= STF_MAX_NODE;
    run(8'h1e, 2, 0, 24);
    node <= 5'h1f;
    run(8'h1f, 2, 0, 24);
    node <= 5'h05;
    pc_len <= 7'h05;
    run(8'h05, 3, 0, 24);
    pc_len <= STF_PC_LEN_VARIABLE;
    pd_words <= 4'h9;
    run(8'h05, 3, 0, 24);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
